// ===== verilog/cpss_sequencer.sv
// Start-up and power-good sequencer for a divide-by-four charge pump.
// Assumes analog comparators and pins arrive asynchronously; all but sync_in
// are synchronised here. Power-good is open drain, pulled up externally.
`default_nettype none
module cpss_sequencer
  import cpss_pkg::*;
#(
  parameter int unsigned SS_TIMEOUT = cpss_pkg::SS_TIMEOUT_CYC,
  parameter int unsigned SHUTDOWN_HOLD = cpss_pkg::SHUTDOWN_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic enable_cmp,
  input wire logic vin_above_rise,
  input wire logic vin_above_fall,
  input wire logic vout_above_pg,
  input wire logic precharge_done,
  input wire logic fault,
  input wire logic clock_direction_select,
  input wire logic int_clk,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  input wire logic power_good_line_in,
  output logic power_good_line_out,
  output logic power_good_line_oe,
  output logic pump_enable,
  output logic precharge_active,
  output logic full_power,
  output logic ext_clk_mode
);
  import cpss_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int NS = 9;
  logic [NS-1:0] raw, s1_q, s2_q;
  // Oscillator level crosses domains too, so it shares the two-flop path
  assign raw = {int_clk, enable_cmp, vin_above_rise, vin_above_fall, vout_above_pg,
                precharge_done, fault, clock_direction_select, power_good_line_in};
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  wire iclk_s = s2_q[8];
  wire en_s = s2_q[7];
  wire vrise_s = s2_q[6];
  wire vfall_s = s2_q[5];
  wire vout_s = s2_q[4];
  wire pre_s = s2_q[3];
  wire fault_s = s2_q[2];
  wire sel_s = s2_q[1];
  wire line_s = s2_q[0];

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  cpss_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic en_prev_q, uv_ok_q, cfg_ext_q, cfg_ext_d;
  // Hysteresis: arm on rising threshold, drop on falling one
  wire uv_ok_d = vrise_s ? 1'b1 : (vfall_s ? uv_ok_q : 1'b0);
  wire en_fall = en_prev_q & ~en_s;
  wire run_ok = en_s & uv_ok_q & ~fault_s;
  wire ss_expired = (cnt_q >= CNT_W'(SS_TIMEOUT - 1));
  wire sd_expired = (cnt_q >= CNT_W'(SHUTDOWN_HOLD - 1));
  wire [CNT_W-1:0] cnt_inc = CNT_W'(cnt_q + CNT_W'(1));

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    cfg_ext_d = cfg_ext_q;
    unique case (st_q)
      CPSS_OFF: begin
        cnt_d = '0;
        // No start, and no re-capture, while a fault is still present
        if (en_s && uv_ok_q && !fault_s) st_d = CPSS_SAMPLE;
      end
      CPSS_SAMPLE: begin
        cfg_ext_d = sel_s;
        st_d = CPSS_PRECHARGE;
      end
      CPSS_PRECHARGE: begin
        cnt_d = '0;
        if (pre_s) st_d = CPSS_SOFTSTART;
      end
      CPSS_SOFTSTART: begin
        cnt_d = cnt_inc;
        // External hold keeps soft-start; timeout only while output short
        if (vout_s && line_s) st_d = CPSS_NORMAL;
        else if (!vout_s && ss_expired) st_d = CPSS_LATCHED;
        if (vout_s) cnt_d = '0;
      end
      CPSS_NORMAL: begin
        cnt_d = '0;
        if (!vout_s || !line_s) st_d = CPSS_SOFTSTART;
      end
      CPSS_LATCHED: cnt_d = '0;
      CPSS_SHUTDOWN: begin
        cnt_d = cnt_inc;
        if (sd_expired) st_d = CPSS_OFF;
      end
      default: st_d = CPSS_OFF;
    endcase
    // Enable loss overrides every phase but off and shutdown; lockout also spares latched
    if (en_fall && st_q != CPSS_OFF && st_q != CPSS_SHUTDOWN) begin
      st_d = CPSS_SHUTDOWN;
      cnt_d = '0;
    end else if (st_q != CPSS_OFF && st_q != CPSS_SHUTDOWN && st_q != CPSS_LATCHED &&
                 (!uv_ok_q || fault_s || !en_s)) begin
      st_d = CPSS_OFF;
      cnt_d = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= CPSS_OFF;
      cnt_q <= '0;
      en_prev_q <= 1'b0;
      uv_ok_q <= 1'b0;
      cfg_ext_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      en_prev_q <= en_s;
      uv_ok_q <= uv_ok_d;
      cfg_ext_q <= cfg_ext_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Pull down in every enabled state but normal; also during shutdown hold.
  // Released once output is reached, else our own pull-down would block the line
  wire ss_reached = (st_d == CPSS_SOFTSTART) && vout_s;
  wire pg_pull_d = (st_d == CPSS_SHUTDOWN) ||
                   (en_s && uv_ok_q && st_d != CPSS_NORMAL && st_d != CPSS_OFF && !ss_reached) ||
                   (en_s && uv_ok_q && fault_s);
  wire pump_d = (st_d == CPSS_SOFTSTART) || (st_d == CPSS_NORMAL);
  // Clock direction follows captured strap only; sync_in is not used anywhere
  wire drive_clk = ~cfg_ext_d;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      power_good_line_oe <= 1'b0;
      pump_enable <= 1'b0;
      precharge_active <= 1'b0;
      full_power <= 1'b0;
      ext_clk_mode <= 1'b0;
      sync_oe <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      power_good_line_oe <= pg_pull_d;
      pump_enable <= pump_d;
      precharge_active <= (st_d == CPSS_PRECHARGE);
      full_power <= (st_d == CPSS_NORMAL);
      ext_clk_mode <= cfg_ext_d;
      sync_oe <= drive_clk;
      sync_out <= drive_clk & iclk_s;
    end
  end
  assign power_good_line_out = 1'b0; // Open drain: only ever drives low

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_pg_normal: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_q == CPSS_NORMAL) |-> !power_good_line_oe)
    else $error("power good pulled in normal state");
  chk_pg_softstart: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_q == CPSS_SOFTSTART && st_d == CPSS_SOFTSTART && !vout_s) |=> power_good_line_oe)
    else $error("power good released during soft-start");
  chk_pg_reached: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_d == CPSS_SOFTSTART && vout_s && !fault_s) |=> !power_good_line_oe)
    else $error("power good pulled after output reached");
  chk_ss_latch: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_q == CPSS_LATCHED && en_s) |=> st_q == CPSS_LATCHED)
    else $error("latched off left without enable toggle");
  chk_sd_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_q == CPSS_SHUTDOWN) |-> power_good_line_oe)
    else $error("power good released during shutdown hold");
  chk_en_fall: assert property (@(posedge sys_clk) disable iff (!nrst)
    (en_fall && st_q == CPSS_NORMAL) |=> st_q == CPSS_SHUTDOWN)
    else $error("enable fall did not start shutdown");
  chk_hold_line: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_q == CPSS_SOFTSTART && !line_s && en_s) |=> st_q != CPSS_NORMAL)
    else $error("left soft-start while line held low");
  chk_off_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_d == CPSS_OFF && !fault_s) |=> !power_good_line_oe)
    else $error("disabled device pulls power good");
  chk_cfg_held: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_q != CPSS_SAMPLE) |=> $stable(cfg_ext_q))
    else $error("configuration changed after capture");
  chk_pump_pre: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_q == CPSS_PRECHARGE && !pre_s && !en_fall) |=> !pump_enable)
    else $error("pump on before pre-charge done");
  chk_uv_stop: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!uv_ok_q && st_q == CPSS_NORMAL) |=> ##1 !pump_enable)
    else $error("pump running below lockout");
endmodule
`default_nettype wire

// ===== verilog/cpss_pkg.sv
// Constants and state types for the charge-pump start-up sequencer.
// Assumes a 20 MHz system clock and comparator results as logic levels.
`default_nettype none
package cpss_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned SS_TIMEOUT_MS = 100;
  localparam int unsigned SHUTDOWN_PG_LOW_MS = 60;
  localparam int unsigned SS_TIMEOUT_CYC = SS_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned SHUTDOWN_CYC = SHUTDOWN_PG_LOW_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 22;
  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CPSS_OFF = 3'b000,
    CPSS_SAMPLE = 3'b001,
    CPSS_PRECHARGE = 3'b010,
    CPSS_SOFTSTART = 3'b011,
    CPSS_NORMAL = 3'b100,
    CPSS_LATCHED = 3'b101,
    CPSS_SHUTDOWN = 3'b110
  } cpss_state_t;
endpackage
`default_nettype wire

// ===== tb/cpss_partner.sv
// Far side of the block: system controller and paralleled modules.
// Assumes an external pull-up; the shared line is a wired AND of pull-downs.
`default_nettype none
module cpss_partner (
  input wire logic en_req,
  input wire logic hold_req,
  input wire logic dut_oe,
  output logic enable_cmp,
  output logic line,
  output logic load_on
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------
  // Shared pins
  // ------------------------------------------
  assign enable_cmp = en_req; // One common enable, never floating
  assign line = ~(dut_oe | hold_req); // Pull-up wins only if nobody pulls
  assign load_on = line & en_req; // No load before the line is high
endmodule
`default_nettype wire

// ===== tb/charge_pump_startup_sequencer_bench.sv
// Bench for the start-up sequencer against a small state model.
// Assumes shortened timeout 50 and shutdown hold 30 cycles.
`default_nettype none
module charge_pump_startup_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------
  // Stimulus and model
  // ------------------------------------------
  logic sys_clk = 1'b0, nrst = 1'b0, en_req = 1'b0, hold_req = 1'b0, ick = 1'b0, rise = 1'b0;
  logic fall = 1'b0, vout = 1'b0, pre_done = 1'b0, flt = 1'b0, strap = 1'b0;
  logic en, line, s_oe, s_out, pg_oe, pump, pre, full, ext;
  int error_cnt = 0, checks = 0, n, c;
  always #25 sys_clk = ~sys_clk;
  always @(negedge sys_clk) ick <= ~ick;
  cpss_partner u_far (.en_req(en_req), .hold_req(hold_req), .dut_oe(pg_oe),
    .enable_cmp(en), .line(line), .load_on());
  cpss_sequencer #(.SS_TIMEOUT(50), .SHUTDOWN_HOLD(30)) DUT (.sys_clk(sys_clk), .nrst(nrst),
    .enable_cmp(en), .vin_above_rise(rise), .vin_above_fall(fall), .vout_above_pg(vout),
    .precharge_done(pre_done), .fault(flt), .clock_direction_select(strap), .int_clk(ick),
    .sync_in(1'b0), .sync_out(s_out), .sync_oe(s_oe), .power_good_line_in(line),
    .power_good_line_out(), .power_good_line_oe(pg_oe), .pump_enable(pump),
    .precharge_active(pre), .full_power(full), .ext_clk_mode(ext));
  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Outputs {pre, pump, full, oe}; 4 is latched, fault or shutdown
  // 5 is soft-start with output reached, waiting for the shared line
  function automatic logic [3:0] mdl(input int s);
    case (s)
      1: return 4'h9;
      2: return 4'h5;
      3: return 4'h6;
      4: return 4'h1;
      5: return 4'h4;
      default: return 4'h0;
    endcase
  endfunction
  task automatic step(input string nm, input int s);
    n = 0;
    while ({pre, pump, full, pg_oe} !== mdl(s) && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    chk(nm, {pre, pump, full, pg_oe}, mdl(s));
  endtask
  task automatic hold(input string nm, input int s);
    repeat (20) @(negedge sys_clk);
    chk(nm, {pre, pump, full, pg_oe}, mdl(s));
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ------------------------------------------
  // Tests
  // ------------------------------------------
  initial begin
    void'($urandom(27385));
    strap = 1'($urandom());
    repeat (16) @(negedge sys_clk);
    chk("reset", {pre, pump, full, pg_oe}, mdl(0));
    nrst = 1'b1;
    rise = 1'b1;
    fall = 1'b1;
    en_req = 1'b1;
    step("precharge", 1);
    chk("strap", {3'h0, ext}, {3'h0, strap});
    chk("sync dir", {3'h0, s_oe}, {3'h0, ~strap});
    c = s_out;
    @(negedge sys_clk);
    chk("sync out", {3'h0, c[0] ^ s_out}, {3'h0, ~strap});
    strap = ~strap;
    repeat ($urandom_range(9, 2)) @(negedge sys_clk);
    pre_done = 1'b1;
    step("softstart", 2);
    vout = 1'b1;
    step("normal", 3);
    chk("cfg held", {3'h0, ext}, {3'h0, ~strap});
    $display("test startup done");
    hold_req = 1'b1;
    step("line held", 5);
    hold("still held", 5);
    hold_req = 1'b0;
    step("line free", 3);
    flt = 1'b1;
    step("fault", 4);
    flt = 1'b0;
    step("recover", 3);
    $display("test parallel done");
    en_req = 1'b0;
    for (n = 0; pg_oe !== 1'b1 && n < 20; n++) @(negedge sys_clk);
    for (c = 0; pg_oe === 1'b1 && c < 100; c++) @(negedge sys_clk);
    chk("shutdown len", {3'h0, c >= 29 && c <= 33}, 4'h1);
    hold("disabled", 0);
    $display("test shutdown done");
    pre_done = 1'b0;
    en_req = 1'b1;
    step("prebias", 1);
    vout = 1'b0;
    pre_done = 1'b1;
    step("ss again", 2);
    step("timeout", 4);
    vout = 1'b1;
    hold("latch held", 4);
    en_req = 1'b0;
    step("toggle off", 0);
    en_req = 1'b1;
    step("restart", 3);
    $display("test timeout done");
    fall = 1'b0;
    rise = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("input_undervoltage_lockout stop", {3'h0, pump}, 4'h0);
    fall = 1'b1;
    repeat (20) @(negedge sys_clk);
    chk("hysteresis", {3'h0, pump}, 4'h0);
    rise = 1'b1;
    step("uv restart", 3);
    $display("test lockout done");
    end_sim();
  end
  initial begin
    #1000000;
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
